// File: src/digitizer_input_gain_offset_regs.sv
// Purpose: Gain, offset, filter and clock/sync select configuration bank
// Assumes: Serial control slave delivers byte writes and reads by subaddress
// Notes: Runs on the internal reference clock domain; outputs are register driven except port-fed upper fine offset bits and tied-high controlUsesInternalRef
// Summary of operation
// [RULE1] Sync-on-green filter code selects glitch filter
// [RULE2] Clamp filter code sets cutoff; 11 reserved
// [RULE3] Clamp filter applies to all enabled clamps
// [RULE4] Bit 3 picks sync reference clock
// [RULE5] Control, separator, activity stay on internal clock
// [RULE6] Host supplies 27 MHz for accurate detection
// [RULE7] Vertical sync select picks input A or B
// [RULE8] Bit 1 picks sample clock source
// [RULE9] Host pairs external clock with external clamp
// [RULE10] Horizontal sync select picks input A or B
// [RULE11] Gain codes map 0.5 to 2.0
// [RULE12] 1Bh holds green and blue gain
// [RULE13] 1Ch holds red gain, resets 07h
// [RULE14] Host keeps gain at most code 1000
// [RULE15] Fine offset low bits at 1Dh
// [RULE16] Coarse offset is sign-magnitude, four counts step
// [RULE17] Coarse offsets at 1Eh-20h reset 10h
// [RULE18] Host avoids coarse offsets below 10h
// [RULE19] Fields read back last written value
`timescale 1ns/1ps
module digitizer_input_gain_offset_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [digo_pkg::ADDR_W-1:0] regAddr,
    input wire logic [digo_pkg::DATA_W-1:0] regWrData,
    output logic [digo_pkg::DATA_W-1:0] regRdData,
    output logic regRdHit,
    input wire logic [9:2] redFineHigh,
    input wire logic [9:2] greenFineHigh,
    input wire logic [9:2] blueFineHigh,
    output digo_pkg::digo_sog_flt_t greenSyncFilterSelect,
    output logic [3:0] sogFilterOneHot,
    output digo_pkg::digo_clp_flt_t coarseClampFilterSelect,
    output logic [2:0] clampFilterOneHot,
    output logic syncRefExternal,
    output logic controlUsesInternalRef,
    output logic verticalSyncInputSelect,
    output logic sampleClockFromPll,
    output logic horizontalSyncInputSelect,
    output logic [4:0] redGainTenths,
    output logic [4:0] greenGainTenths,
    output logic [4:0] blueGainTenths,
    output logic [9:0] redFineOffset,
    output logic [9:0] greenFineOffset,
    output logic [9:0] blueFineOffset,
    output logic signed [8:0] redCoarseCounts,
    output logic signed [8:0] greenCoarseCounts,
    output logic signed [8:0] blueCoarseCounts
);
    import digo_pkg::*;

    localparam int NUM_REGS = 7;
    localparam int NUM_CH = 3;
    localparam int SLOT_W = 3;

    // Storage slots follow subaddress order, so a slot is an address offset
    localparam int SLOT_MUX2 = SUB_MUX2 - SUB_MUX2;
    localparam int SLOT_BG_GAIN = SUB_BG_GAIN - SUB_MUX2;
    localparam int SLOT_R_GAIN = SUB_R_GAIN - SUB_MUX2;
    localparam int SLOT_FINE_LO = SUB_FINE_LO - SUB_MUX2;
    localparam int SLOT_B_COFS = SUB_B_COFS - SUB_MUX2;
    localparam int SLOT_G_COFS = SUB_G_COFS - SUB_MUX2;
    localparam int SLOT_R_COFS = SUB_R_COFS - SUB_MUX2;

    // Channel order of the per-channel arrays
    localparam int CH_RED = 0;
    localparam int CH_GREEN = 1;
    localparam int CH_BLUE = 2;

    // Field positions inside the gain, fine and coarse offset bytes
    localparam int GAIN_W = 4;
    localparam int GAIN_UPPER_LSB = 4;
    localparam int GAIN_LOWER_LSB = 0;
    localparam int PAIR_W = 2;
    localparam int FINE_R_LSB = 4;
    localparam int FINE_G_LSB = 2;
    localparam int FINE_B_LSB = 0;
    localparam int COFS_W = 6;
    localparam int FINE_HIGH_W = 8;
    localparam int FINE_W = 10;

    // True for the seven subaddresses of this bank
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a >= SUB_MUX2) && (a <= SUB_R_COFS);
    endfunction

    // Only meaningful while isMapped holds
    function automatic logic [SLOT_W-1:0] slotOf(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - SUB_MUX2;
        slotOf = rel[SLOT_W-1:0];
    endfunction

    function automatic logic [7:0] resetOf(input int s);
        case (s)
            SLOT_MUX2: resetOf = RST_MUX2; // [RULE1]
            SLOT_BG_GAIN: resetOf = RST_BG_GAIN; // [RULE12]
            SLOT_R_GAIN: resetOf = RST_R_GAIN; // [RULE13]
            SLOT_FINE_LO: resetOf = RST_FINE_LO; // [RULE15]
            SLOT_B_COFS: resetOf = RST_COFS; // [RULE17]
            SLOT_G_COFS: resetOf = RST_COFS; // [RULE17]
            SLOT_R_COFS: resetOf = RST_COFS; // [RULE17]
            default: resetOf = '0;
        endcase
    endfunction

    // Reserved bits are cleared on write so they read back as zero
    function automatic logic [7:0] maskOf(input int s);
        case (s)
            SLOT_R_GAIN: maskOf = MASK_R_GAIN; // [RULE13]
            SLOT_FINE_LO: maskOf = MASK_FINE_LO; // [RULE15]
            SLOT_B_COFS: maskOf = MASK_COFS; // [RULE17]
            SLOT_G_COFS: maskOf = MASK_COFS; // [RULE17]
            SLOT_R_COFS: maskOf = MASK_COFS; // [RULE17]
            default: maskOf = '1;
        endcase
    endfunction

    logic [7:0] cfg_ff [NUM_REGS];
    logic [7:0] rdData_ff;
    logic rdHit_ff;
    wire logic [7:0] nxt_cfg [NUM_REGS];
    wire logic [NUM_REGS-1:0] wrSel;
    wire logic wrMapped;
    wire logic [SLOT_W-1:0] accSlot;
    wire logic [7:0] nxt_rdData;
    wire logic nxt_rdHit;

    assign wrMapped = regWrEn && isMapped(regAddr);
    assign accSlot = slotOf(regAddr);

    // One flip-flop byte per subaddress; unmapped writes touch nothing.
    // The mux select byte keeps all eight bits, reserved clamp code included.
    genvar gr;
    generate
        for (gr = 0; gr < NUM_REGS; gr++) begin : gRegs
            localparam logic [7:0] RST_VAL = resetOf(gr);
            localparam logic [7:0] WR_MASK = maskOf(gr);
            assign wrSel[gr] = wrMapped && (accSlot == SLOT_W'(gr));
            assign nxt_cfg[gr] = wrSel[gr] ? (regWrData & WR_MASK) : cfg_ff[gr]; // [RULE19]

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_ff[gr] <= RST_VAL;
                end else begin
                    cfg_ff[gr] <= nxt_cfg[gr];
                end
            end
        end
    endgenerate

    // Named views of the bank, one per subaddress
    wire logic [7:0] inputFilterClockSyncSelect;
    wire logic [7:0] blueGreenCoarseGain;
    wire logic [7:0] redCoarseGain;
    wire logic [7:0] fineOffsetLowBits;
    wire logic [7:0] blueCoarseOffset;
    wire logic [7:0] greenCoarseOffset;
    wire logic [7:0] redCoarseOffset;
    assign inputFilterClockSyncSelect = cfg_ff[SLOT_MUX2];
    assign blueGreenCoarseGain = cfg_ff[SLOT_BG_GAIN];
    assign redCoarseGain = cfg_ff[SLOT_R_GAIN];
    assign fineOffsetLowBits = cfg_ff[SLOT_FINE_LO];
    assign blueCoarseOffset = cfg_ff[SLOT_B_COFS];
    assign greenCoarseOffset = cfg_ff[SLOT_G_COFS];
    assign redCoarseOffset = cfg_ff[SLOT_R_COFS];

    // A read and a write on one edge return the old byte
    assign nxt_rdHit = isMapped(regAddr);
    assign nxt_rdData = nxt_rdHit ? cfg_ff[accSlot] : '0; // [RULE19]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= '0;
            rdHit_ff <= 1'b0;
        end else if (regRdEn) begin
            rdData_ff <= nxt_rdData;
            rdHit_ff <= nxt_rdHit;
        end
    end

    assign regRdData = rdData_ff;
    assign regRdHit = rdHit_ff;

    // Field decode of the filter, clock and sync select byte
    wire logic [1:0] sogCode;
    wire logic [1:0] clpCode;
    wire logic refClkBit;
    wire logic vsSelBit;
    wire logic smpClkBit;
    wire logic hsSelBit;
    assign sogCode = inputFilterClockSyncSelect[SOG_FLT_HI:SOG_FLT_LO];
    assign clpCode = inputFilterClockSyncSelect[CLP_FLT_HI:CLP_FLT_LO];
    assign refClkBit = inputFilterClockSyncSelect[REF_CLK_BIT];
    assign vsSelBit = inputFilterClockSyncSelect[VERTICAL_SYNC_INPUT_SELECT_BIT];
    assign smpClkBit = inputFilterClockSyncSelect[SMP_CLK_BIT];
    assign hsSelBit = inputFilterClockSyncSelect[HORIZONTAL_SYNC_INPUT_SELECT_BIT];

    assign greenSyncFilterSelect = digo_sog_flt_t'(sogCode); // [RULE1]
    assign sogFilterOneHot = 4'h1 << sogCode; // [RULE1]
    // Reserved clamp code reads back as written but never reaches the analog stage
    assign coarseClampFilterSelect = (clpCode == DIGO_CLP_RSV) ? DIGO_CLP_4M8
                                     : digo_clp_flt_t'(clpCode); // [RULE2]
    // One select shared by every enabled coarse clamp
    assign clampFilterOneHot = 3'h1 << coarseClampFilterSelect; // [RULE3]
    assign syncRefExternal = refClkBit; // [RULE4]
    // Register access and sync separation never follow the reference select
    assign controlUsesInternalRef = 1'b1; // [RULE5]
    assign verticalSyncInputSelect = vsSelBit; // [RULE7]
    assign sampleClockFromPll = smpClkBit; // [RULE8]
    assign horizontalSyncInputSelect = hsSelBit; // [RULE10]

    // Per-channel codes, indexed by CH_RED, CH_GREEN and CH_BLUE
    wire logic [GAIN_W-1:0] gainCode [NUM_CH];
    wire logic [PAIR_W-1:0] fineLoPair [NUM_CH];
    wire logic [FINE_HIGH_W-1:0] fineHigh [NUM_CH];
    wire logic [COFS_W-1:0] cofsCode [NUM_CH];
    wire logic [4:0] gainTenths [NUM_CH];
    wire logic [FINE_W-1:0] fineFull [NUM_CH];
    wire logic signed [8:0] cofsCounts [NUM_CH];

    assign gainCode[CH_RED] = redCoarseGain[GAIN_LOWER_LSB +: GAIN_W]; // [RULE13]
    assign gainCode[CH_GREEN] = blueGreenCoarseGain[GAIN_UPPER_LSB +: GAIN_W]; // [RULE12]
    assign gainCode[CH_BLUE] = blueGreenCoarseGain[GAIN_LOWER_LSB +: GAIN_W]; // [RULE12]

    assign fineLoPair[CH_RED] = fineOffsetLowBits[FINE_R_LSB +: PAIR_W]; // [RULE15]
    assign fineLoPair[CH_GREEN] = fineOffsetLowBits[FINE_G_LSB +: PAIR_W]; // [RULE15]
    assign fineLoPair[CH_BLUE] = fineOffsetLowBits[FINE_B_LSB +: PAIR_W]; // [RULE15]

    // Upper eight fine bits live outside this bank
    assign fineHigh[CH_RED] = redFineHigh;
    assign fineHigh[CH_GREEN] = greenFineHigh;
    assign fineHigh[CH_BLUE] = blueFineHigh;

    assign cofsCode[CH_RED] = redCoarseOffset[COFS_W-1:0]; // [RULE17]
    assign cofsCode[CH_GREEN] = greenCoarseOffset[COFS_W-1:0]; // [RULE17]
    assign cofsCode[CH_BLUE] = blueCoarseOffset[COFS_W-1:0]; // [RULE17]

    // Same gain, fine and coarse offset path for every channel
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : gChan
            digo_gain_map uGain (
                .code(gainCode[gc]),
                .gainTenths(gainTenths[gc])
            ); // [RULE11]

            assign fineFull[gc] = {fineHigh[gc], fineLoPair[gc]}; // [RULE15]

            digo_coarse_offset uCofs (
                .code(cofsCode[gc]),
                .counts(cofsCounts[gc])
            ); // [RULE16]
        end
    endgenerate

    assign redGainTenths = gainTenths[CH_RED];
    assign greenGainTenths = gainTenths[CH_GREEN];
    assign blueGainTenths = gainTenths[CH_BLUE];

    assign redFineOffset = fineFull[CH_RED];
    assign greenFineOffset = fineFull[CH_GREEN];
    assign blueFineOffset = fineFull[CH_BLUE];

    assign redCoarseCounts = cofsCounts[CH_RED];
    assign greenCoarseCounts = cofsCounts[CH_GREEN];
    assign blueCoarseCounts = cofsCounts[CH_BLUE];
endmodule

// File: src/digo_coarse_offset.sv
// Purpose: Turns a 6-bit sign-magnitude coarse offset into signed counts
// Assumes: Four converter counts per magnitude step
// Notes: Both signs of zero give zero
`timescale 1ns/1ps
module digo_coarse_offset (
    input wire logic [5:0] code,
    output logic signed [8:0] counts
);
    import digo_pkg::*;
    wire logic [7:0] magCounts;
    assign magCounts = {code[4:0], 2'b00}; // [RULE16]
    assign counts = code[COFS_SIGN_BIT] ? -$signed({1'b0, magCounts})
                                        : $signed({1'b0, magCounts}); // [RULE16]
endmodule

// File: src/digo_gain_map.sv
// Purpose: Maps a 4-bit coarse gain code to gain in tenths
// Assumes: Analog stage consumes gain as tenths
// Notes: Code 1110 is held at 1.8 as the device defines it
`timescale 1ns/1ps
module digo_gain_map (
    input wire logic [3:0] code,
    output logic [4:0] gainTenths
);
    import digo_pkg::*;
    localparam logic [4:0] GAIN_BASE = 5'h05;
    localparam logic [3:0] CODE_ODD = 4'he;
    localparam logic [4:0] GAIN_ODD = 5'h12;
    wire logic [4:0] linear;
    assign linear = GAIN_BASE + {1'b0, code}; // [RULE11]
    assign gainTenths = (code == CODE_ODD) ? GAIN_ODD : linear; // [RULE11]
endmodule

// File: src/digo_pkg.sv
// Purpose: Shared constants for the digitizer gain/offset configuration bank
// Assumes: Byte-wide subaddressed access from the serial control slave
// Notes: Subaddresses are the device's own, used as printed
package digo_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] SUB_MUX2 = 8'h1a;
    localparam logic [7:0] SUB_BG_GAIN = 8'h1b;
    localparam logic [7:0] SUB_R_GAIN = 8'h1c;
    localparam logic [7:0] SUB_FINE_LO = 8'h1d;
    localparam logic [7:0] SUB_B_COFS = 8'h1e;
    localparam logic [7:0] SUB_G_COFS = 8'h1f;
    localparam logic [7:0] SUB_R_COFS = 8'h20;

    localparam logic [7:0] RST_MUX2 = 8'hc2;
    localparam logic [7:0] RST_BG_GAIN = 8'h77;
    localparam logic [7:0] RST_R_GAIN = 8'h07;
    localparam logic [7:0] RST_FINE_LO = 8'h00;
    localparam logic [7:0] RST_COFS = 8'h10;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_R_GAIN = 8'h0f;
    localparam logic [7:0] MASK_FINE_LO = 8'h3f;
    localparam logic [7:0] MASK_COFS = 8'h3f;

    // Field positions inside the mux select register
    localparam int SOG_FLT_HI = 7;
    localparam int SOG_FLT_LO = 6;
    localparam int CLP_FLT_HI = 5;
    localparam int CLP_FLT_LO = 4;
    localparam int REF_CLK_BIT = 3;
    localparam int VERTICAL_SYNC_INPUT_SELECT_BIT = 2;
    localparam int SMP_CLK_BIT = 1;
    localparam int HORIZONTAL_SYNC_INPUT_SELECT_BIT = 0;

    localparam int COFS_SIGN_BIT = 5;
    localparam int COFS_STEP_SHIFT = 2;

    typedef enum logic [1:0] {
        DIGO_SOG_2M5 = 2'b00,
        DIGO_SOG_10M = 2'b01,
        DIGO_SOG_33M = 2'b10,
        DIGO_SOG_BYP = 2'b11
    } digo_sog_flt_t;

    typedef enum logic [1:0] {
        DIGO_CLP_4M8 = 2'b00,
        DIGO_CLP_0M5 = 2'b01,
        DIGO_CLP_1M7 = 2'b10,
        DIGO_CLP_RSV = 2'b11
    } digo_clp_flt_t;
endpackage

// File: tb/digitizer_input_gain_offset_regs_tb.sv
// Purpose: Register-level regression of the gain/offset bank
// Assumes: Fixed one-cycle write and read latency
// Notes: Expected values come from hand tables
`timescale 1ns/1ps
module digitizer_input_gain_offset_regs_tb;
    import digo_pkg::*;
    logic sys_clk, rst_n, regWrEn, regRdEn, regRdHit, syncRefExternal, hit;
    logic controlUsesInternalRef, verticalSyncInputSelect, sampleClockFromPll;
    logic horizontalSyncInputSelect;
    logic [7:0] regAddr, regWrData, regRdData, redFineHigh, greenFineHigh, blueFineHigh, d;
    digo_sog_flt_t greenSyncFilterSelect;
    digo_clp_flt_t coarseClampFilterSelect;
    logic [3:0] sogFilterOneHot;
    logic [2:0] clampFilterOneHot;
    logic [4:0] redGainTenths, greenGainTenths, blueGainTenths;
    logic [9:0] redFineOffset, greenFineOffset, blueFineOffset;
    logic signed [8:0] redCoarseCounts, greenCoarseCounts, blueCoarseCounts;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] rstVal [7] = '{8'hc2, 8'h77, 8'h07, 8'h00, 8'h10, 8'h10, 8'h10};
    logic [5:0] cCode [7] = '{6'h1f, 6'h10, 6'h01, 6'h00, 6'h20, 6'h21, 6'h3f};
    int cExp [7] = '{124, 64, 4, 0, 0, -4, -124};
    digitizer_input_gain_offset_regs dut (.*);
    digo_host_model host (.*);
    task automatic chk(string nm, logic signed [9:0] e, logic signed [9:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic rchk(logic [7:0] a, logic [7:0] e, logic h);
        host.rd(a, d, hit);
        chk("read data", e, d);
        chk("read hit", h, hit);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        redFineHigh = 8'h5a;
        greenFineHigh = 8'h81;
        blueFineHigh = 8'h3c;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        for (int i = 0; i < 7; i++) rchk(8'h1a + i[7:0], rstVal[i], 1'b1);
        $display("reset done");
        for (int i = 0; i < 16; i++) begin
            host.wr(SUB_R_GAIN, 8'hf0 | i[7:0]);
            chk("red gain", (i == 14) ? 18 : 5 + i, redGainTenths);
            rchk(SUB_R_GAIN, i[7:0], 1'b1);
        end
        host.wr(SUB_BG_GAIN, 8'he8);
        chk("green gain", 18, greenGainTenths);
        chk("blue gain", 13, blueGainTenths);
        $display("gain done");
        for (int i = 0; i < 4; i++) begin
            d = 8'h55 * i[7:0];
            host.wr(SUB_MUX2, d);
            chk("sog", d[7:6], greenSyncFilterSelect);
            chk("sog hot", 4'h1 << d[7:6], sogFilterOneHot);
            chk("clamp", d[5:4] == 2'h3 ? 2'h0 : d[5:4], coarseClampFilterSelect);
            chk("clamp hot", 3'h1 << (d[5:4] == 2'h3 ? 2'h0 : d[5:4]), clampFilterOneHot);
            chk("selects", d[3:0], {syncRefExternal, verticalSyncInputSelect,
                sampleClockFromPll, horizontalSyncInputSelect});
            chk("int ref", 1, controlUsesInternalRef);
            rchk(SUB_MUX2, 8'h55 * i[7:0], 1'b1);
        end
        $display("mux done");
        foreach (cCode[i]) begin
            for (int a = 0; a < 3; a++) host.wr(SUB_B_COFS + a[7:0], {2'h3, cCode[i]});
            chk("blue ofs", cExp[i], blueCoarseCounts);
            chk("green ofs", cExp[i], greenCoarseCounts);
            chk("red ofs", cExp[i], redCoarseCounts);
            rchk(SUB_R_COFS, {2'h0, cCode[i]}, 1'b1);
        end
        host.wr(SUB_FINE_LO, 8'he4);
        chk("red fine", {redFineHigh, 2'h2}, redFineOffset);
        chk("green fine", {greenFineHigh, 2'h1}, greenFineOffset);
        chk("blue fine", {blueFineHigh, 2'h0}, blueFineOffset);
        rchk(SUB_FINE_LO, 8'h24, 1'b1);
        $display("offset done");
        host.wr(8'h21, 8'h00);
        rchk(8'h21, 8'h00, 1'b0);
        rchk(8'h19, 8'h00, 1'b0);
        rchk(SUB_MUX2, 8'hff, 1'b1);
        // Setup a careful host uses: external reference and sample clock
        host.wr(SUB_MUX2, 8'hc8);
        chk("ext ref", 1, syncRefExternal);
        chk("ext sample", 0, sampleClockFromPll);
        host.wr(SUB_R_GAIN, 8'h08);
        chk("red gain", 13, redGainTenths);
        host.wr(SUB_R_COFS, 8'h10);
        chk("red ofs", 64, redCoarseCounts);
        $display("host setup done");
        @(negedge sys_clk) rst_n = 1'b0;
        @(negedge sys_clk) rst_n = 1'b1;
        rchk(SUB_MUX2, 8'hc2, 1'b1);
        chk("red gain", 12, redGainTenths);
        $display("refusal and reset done");
        tally_and_finish();
    end
endmodule

// File: tb/digo_host_model.sv
// Purpose: Host stand-in issuing byte accesses
// Assumes: Strobes move on the falling edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module digo_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] regRdData,
    input wire logic regRdHit,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge sys_clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
        h = regRdHit;
    endtask
endmodule

// File: tb/digo_regs_assertions.sv
// Purpose: Port checks of the gain/offset bank
// Assumes: One clock, async active-low reset
// Notes: Bound onto the design top
`timescale 1ns/1ps
module digo_regs_assertions (
    input wire logic sys_clk, rst_n, regWrEn, regRdEn, regRdHit,
    input wire logic [7:0] regAddr, regWrData, regRdData,
    input wire digo_pkg::digo_sog_flt_t greenSyncFilterSelect,
    input wire digo_pkg::digo_clp_flt_t coarseClampFilterSelect,
    input wire logic syncRefExternal, sampleClockFromPll,
    input wire logic [4:0] redGainTenths,
    input wire logic [9:0] blueFineOffset,
    input wire logic signed [8:0] blueCoarseCounts
);
    import digo_pkg::*;
    logic [7:0] wAddr;
    // Idle writes decode to an unmapped subaddress
    assign wAddr = regWrEn ? regAddr : 8'hff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    function automatic logic signed [8:0] cofs(logic [5:0] c);
        return c[5] ? 9'h0 - {c[4:0], 2'h0} : {2'h0, c[4:0], 2'h0};
    endfunction
    a_reset_state: assert property ($rose(rst_n) |->
        sampleClockFromPll && redGainTenths == 5'h0c) else $error("reset state");
    a_gain_map: assert property (wAddr == SUB_R_GAIN |=> redGainTenths ==
        ($past(regWrData[3:0]) == 4'he ? 5'h12 : 5'h05 + $past(regWrData[3:0])))
        else $error("gain map");
    a_clock_bits: assert property (wAddr == SUB_MUX2 |=>
        {syncRefExternal, sampleClockFromPll} == {$past(regWrData[3]), $past(regWrData[1])})
        else $error("clock selects");
    a_sog_sel: assert property (wAddr == SUB_MUX2 |=>
        greenSyncFilterSelect == $past(regWrData[7:6])) else $error("sog select");
    a_clamp_map: assert property (wAddr == SUB_MUX2 |=> coarseClampFilterSelect ==
        ($past(regWrData[5:4]) == 2'h3 ? 2'h0 : $past(regWrData[5:4]))) else $error("clamp");
    a_fine_low: assert property (wAddr == SUB_FINE_LO |=>
        blueFineOffset[1:0] == $past(regWrData[1:0])) else $error("fine low");
    a_coarse_sign: assert property (wAddr == SUB_B_COFS |=>
        blueCoarseCounts == cofs($past(regWrData[5:0]))) else $error("coarse");
    a_read_miss: assert property (regRdEn && (regAddr < 8'h1a || regAddr > 8'h20)
        |=> !regRdHit && regRdData == 8'h00) else $error("unmapped read");
    c_mux: cover property (wAddr == SUB_MUX2 ##1 syncRefExternal);
    c_neg: cover property (wAddr == SUB_B_COFS && regWrData[5]);
    c_miss: cover property (regRdEn ##1 !regRdHit);
endmodule
bind digitizer_input_gain_offset_regs digo_regs_assertions u_chk (.*);
